// ---- hw/pqb_pkg.sv ----
package pqb_pkg;
  localparam int NUM_QUEUES     = 4;
  localparam int NUM_SOURCES    = 3;
  localparam int NUM_CONSUMERS  = 2;
  localparam int COUNT_W        = 13;
  localparam int DATA_W         = 32;
  localparam int LARGE_Q        = 0;
  localparam int START_MARK_BIT = 16;

  // Producer indices on the source ports
  localparam int SRC_SENSOR_ENGINE = 0;
  localparam int SRC_FABRIC        = 1;
  localparam int SRC_LOCAL_CPU     = 2;

  // Consumer indices; also the value of a queue's pop_owner bit
  localparam int CONS_HOST      = 0;
  localparam int CONS_LOCAL_CPU = 1;

  // Bit positions in each queue's event vector
  localparam int EV_OVERFLOW  = 0;
  localparam int EV_UNDERFLOW = 1;
  localparam int EV_THRESHOLD = 2;
  localparam int EV_ASLEEP    = 3;
  localparam int EV_COLLISION = 4;
  localparam int NUM_EVENTS   = 5;

  typedef logic [1:0]            pqb_qsel_type;
  typedef logic [COUNT_W-1:0]    pqb_count_type;
  typedef logic [DATA_W-1:0]     pqb_data_type;
  typedef logic [NUM_EVENTS-1:0] pqb_events_type;

  typedef enum logic {
    PQB_DRAIN_IDLE = 1'b0,
    PQB_DRAIN_BUSY = 1'b1
  } pqb_drain_type;

  localparam pqb_count_type COUNT_RESET = 13'h0000;
endpackage

// ---- hw/pqb_queue_if.sv ----
interface pqb_queue_if #(
  parameter int W = 32
);
  logic                   push_valid;
  logic [W-1:0]           push_data;
  logic                   push_end;
  logic                   push_ready;
  logic                   pop_req;
  logic                   pop_valid;
  logic [W-1:0]           pop_data;
  pqb_pkg::pqb_count_type count;
  logic                   packet_mode;
  logic                   overflow;
  logic                   underflow;

  modport queue (
    input  push_valid, push_data, push_end, pop_req, packet_mode,
    output push_ready, pop_valid, pop_data, count, overflow, underflow
  );
  modport user (
    output push_valid, push_data, push_end, pop_req, packet_mode,
    input  push_ready, pop_valid, pop_data, count, overflow, underflow
  );
endinterface

// ---- hw/pqb_fifo.sv ----
module pqb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic  mclk,
  input wire logic  rst,
  pqb_queue_if.queue qif
);
  import pqb_pkg::*;

  // DEPTH must be a power of two
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef logic [AW:0] pqb_ptr_type;
  localparam pqb_ptr_type FULL = pqb_ptr_type'(DEPTH);

  typedef struct packed {
    pqb_ptr_type wr;
    pqb_ptr_type cm;
    pqb_ptr_type rd;
  } pqb_fifo_state_type;

  pqb_fifo_state_type st_reg;
  pqb_fifo_state_type st_next;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic [WIDTH-1:0]   head_reg;
  pqb_ptr_type        stored;
  pqb_ptr_type        visible;
  logic               push_ok;
  logic               pop_ok;

  always_comb begin
    stored  = st_reg.wr - st_reg.rd;
    // Packet mode counts only up to the last committed packet end
    visible = qif.packet_mode ? (st_reg.cm - st_reg.rd) : stored;
    push_ok = qif.push_valid && (stored != FULL);
    pop_ok  = qif.pop_req && (visible != '0);
    st_next = st_reg;
    if (push_ok) begin
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop_ok) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
    if (!qif.packet_mode || (push_ok && qif.push_end)) begin
      st_next.cm = st_next.wr;
    end
  end

  assign qif.push_ready = (stored != FULL);
  assign qif.pop_valid  = (visible != '0);
  assign qif.pop_data   = head_reg;
  assign qif.count      = COUNT_W'(visible);
  assign qif.overflow   = qif.push_valid && (stored == FULL);
  assign qif.underflow  = qif.pop_req && (visible == '0);

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Head register shows the next word to pop; the bypass covers a write
  // landing on the head slot in the same edge the head moves there
  always_ff @(posedge mclk) begin
    if (push_ok) begin
      mem[st_reg.wr[AW-1:0]] <= qif.push_data;
    end
    if (push_ok && (st_reg.wr[AW-1:0] == st_next.rd[AW-1:0])) begin
      head_reg <= qif.push_data;
    end else begin
      head_reg <= mem[st_next.rd[AW-1:0]];
    end
  end

  a_pkt_hidden: assert property (@(posedge mclk) disable iff (rst)
    qif.packet_mode && push_ok && !qif.push_end && !pop_ok
    |=> !qif.packet_mode || (qif.count == $past(qif.count)))
    else $error("unfinished packet word became visible");

  a_normal_push: assert property (@(posedge mclk) disable iff (rst)
    !qif.packet_mode && push_ok && !pop_ok
    |=> qif.packet_mode || (qif.count == $past(qif.count) + 1'b1))
    else $error("normal mode count did not follow push");

  a_pkt_commit: assert property (@(posedge mclk) disable iff (rst)
    qif.packet_mode && push_ok && qif.push_end && !pop_ok
    |=> !qif.packet_mode || (qif.count == COUNT_W'(stored)))
    else $error("packet end did not commit all stored words");

  a_no_overrun: assert property (@(posedge mclk) disable iff (rst)
    qif.overflow |=> (st_reg.wr == $past(st_reg.wr))
    && ((stored == FULL) || $past(pop_ok)))
    else $error("push accepted while queue full");
endmodule

// ---- hw/pqb_packet_queue_bank.sv ----
module pqb_packet_queue_bank #(
  parameter int DEPTH_LARGE = 4096,
  parameter int WIDTH_LARGE = 17,
  parameter int DEPTH_Q1    = 256,
  parameter int DEPTH_Q2    = 128,
  parameter int DEPTH_Q3    = 128
) (
  input  wire logic                                           mclk,
  input  wire logic                                           rst,
  input  wire logic [pqb_pkg::NUM_SOURCES-1:0]                src_valid,
  input  wire pqb_pkg::pqb_qsel_type [pqb_pkg::NUM_SOURCES-1:0] src_queue,
  input  wire pqb_pkg::pqb_data_type [pqb_pkg::NUM_SOURCES-1:0] src_data,
  input  wire logic [pqb_pkg::NUM_SOURCES-1:0]                src_end,
  output logic [pqb_pkg::NUM_SOURCES-1:0]                     src_ready,
  input  wire logic                                           packet_mode_en,
  input  wire logic                                           ring_mode_en,
  input  wire pqb_pkg::pqb_count_type [pqb_pkg::NUM_QUEUES-1:0] queue_threshold,
  input  wire logic [pqb_pkg::NUM_QUEUES-1:0]                 queue_asleep,
  input  wire logic [pqb_pkg::NUM_QUEUES-1:0]                 pop_owner,
  input  wire logic [pqb_pkg::NUM_CONSUMERS-1:0]              cons_pop_req,
  input  wire pqb_pkg::pqb_qsel_type [pqb_pkg::NUM_CONSUMERS-1:0] cons_pop_queue,
  output logic [pqb_pkg::NUM_CONSUMERS-1:0]                   cons_pop_ready,
  output pqb_pkg::pqb_data_type [pqb_pkg::NUM_CONSUMERS-1:0]  cons_data,
  output logic [pqb_pkg::NUM_CONSUMERS-1:0]                   cons_data_valid,
  output pqb_pkg::pqb_count_type [pqb_pkg::NUM_QUEUES-1:0]    queue_count,
  output logic [pqb_pkg::NUM_QUEUES-1:0]                      queue_empty,
  output logic [pqb_pkg::NUM_QUEUES-1:0]                      thr_irq,
  output pqb_pkg::pqb_events_type [pqb_pkg::NUM_QUEUES-1:0]   queue_events,
  output logic                                                exc_irq,
  output logic                                                drainer_busy
);
  import pqb_pkg::*;

  localparam int NQ = NUM_QUEUES;
  localparam int NS = NUM_SOURCES;
  localparam int NC = NUM_CONSUMERS;
  localparam int LQ = LARGE_Q;

  typedef struct packed {
    pqb_drain_type                  drain;
    pqb_data_type [NC-1:0]          cons_data;
    logic [NC-1:0]                  cons_valid;
    pqb_count_type [NQ-1:0]         count;
    logic [NQ-1:0]                  empty;
    logic [NQ-1:0]                  thr;
    pqb_events_type [NQ-1:0]        events;
    logic                           exc;
  } pqb_bank_state_type;

  pqb_bank_state_type     st_reg;
  pqb_bank_state_type     st_next;

  logic [NQ-1:0]          q_push_valid;
  logic [NQ-1:0]          q_push_ready;
  logic [NQ-1:0]          q_push_end;
  logic [NQ-1:0]          q_pop_req;
  logic [NQ-1:0]          q_pop_valid;
  logic [NQ-1:0]          q_ovf;
  logic [NQ-1:0]          q_udf;
  pqb_data_type [NQ-1:0]  q_push_data;
  pqb_data_type [NQ-1:0]  q_pop_data;
  pqb_count_type [NQ-1:0] q_count;
  logic [NQ-1:0]          collide;
  logic [NQ-1:0]          sleep_hit;
  logic [NS-1:0]          src_win;
  logic                   drain_pop;
  logic                   drain_blocks;
  logic                   head_start;

  function automatic int depth_of(input int q);
    unique case (q)
      0: return DEPTH_LARGE;
      1: return DEPTH_Q1;
      2: return DEPTH_Q2;
      default: return DEPTH_Q3;
    endcase
  endfunction

  // Request valid and aimed at queue q
  function automatic logic aims_at(input logic v, input pqb_qsel_type sel,
                                   input int q);
    return v && (sel == pqb_qsel_type'(q));
  endfunction

  for (genvar g = 0; g < NQ; g++) begin : g_queue
    localparam int W = (g == LQ) ? WIDTH_LARGE : DATA_W;
    pqb_queue_if #(.W(W)) qif ();

    assign qif.push_valid  = q_push_valid[g];
    assign qif.push_data   = q_push_data[g][W-1:0];
    assign qif.push_end    = q_push_end[g];
    assign qif.pop_req     = q_pop_req[g];
    // Small queues are fixed in normal mode
    assign qif.packet_mode = (g == LQ) ? packet_mode_en : 1'b0;
    assign q_push_ready[g] = qif.push_ready;
    assign q_pop_valid[g]  = qif.pop_valid;
    assign q_pop_data[g]   = DATA_W'(qif.pop_data);
    assign q_count[g]      = qif.count;
    assign q_ovf[g]        = qif.overflow;
    assign q_udf[g]        = qif.underflow;

    pqb_fifo #(
      .WIDTH (W),
      .DEPTH (depth_of(g))
    ) u_fifo (
      .mclk (mclk),
      .rst  (rst),
      .qif  (qif)
    );
  end

  assign head_start = q_pop_data[LQ][START_MARK_BIT];

  always_comb begin
    st_next         = st_reg;
    st_next.cons_valid = '0;
    q_push_valid    = '0;
    q_push_data     = '0;
    q_push_end      = '0;
    q_pop_req       = '0;
    collide         = '0;
    sleep_hit       = '0;
    src_win         = '0;
    src_ready       = '0;
    cons_pop_ready  = '0;
    drain_pop       = 1'b0;

    // Push side: lowest source index wins a contested queue
    for (int q = 0; q < NQ; q++) begin
      for (int s = 0; s < NS; s++) begin
        if (aims_at(src_valid[s], src_queue[s], q)) begin
          if (q_push_valid[q]) begin
            collide[q] = 1'b1;
          end else begin
            q_push_valid[q] = 1'b1;
            q_push_data[q]  = src_data[s];
            q_push_end[q]   = src_end[s];
            src_win[s]      = 1'b1;
          end
        end
      end
      if (queue_asleep[q]) begin
        sleep_hit[q]    = q_push_valid[q];
        q_push_valid[q] = 1'b0;
      end
    end
    for (int s = 0; s < NS; s++) begin
      src_ready[s] = src_win[s] && q_push_ready[src_queue[s]]
                     && !queue_asleep[src_queue[s]];
    end

    // Drainer: enable looked at only when a packet pop begins
    unique case (st_reg.drain)
      PQB_DRAIN_IDLE: begin
        if (ring_mode_en && q_pop_valid[LQ]
            && (q_count[LQ] >= queue_threshold[LQ])) begin
          drain_pop     = 1'b1;
          st_next.drain = PQB_DRAIN_BUSY;
        end
      end
      PQB_DRAIN_BUSY: begin
        // Stop at the next start marker or when committed words run out
        if (q_pop_valid[LQ] && !head_start) begin
          drain_pop = 1'b1;
        end else begin
          st_next.drain = PQB_DRAIN_IDLE;
        end
      end
    endcase
    drain_blocks = (st_reg.drain == PQB_DRAIN_BUSY) || drain_pop;

    // Pop side: host, local CPU and the drainer have a pop path
    for (int c = 0; c < NC; c++) begin
      for (int q = 0; q < NQ; q++) begin
        if (aims_at(cons_pop_req[c], cons_pop_queue[c], q)
            && (pop_owner[q] == c[0])) begin
          if (queue_asleep[q]) begin
            sleep_hit[q] = 1'b1;
          end else if (!((q == LQ) && drain_blocks)) begin
            q_pop_req[q]      = 1'b1;
            cons_pop_ready[c] = q_pop_valid[q];
            if (q_pop_valid[q]) begin
              st_next.cons_data[c]  = q_pop_data[q];
              st_next.cons_valid[c] = 1'b1;
            end
          end
        end
      end
    end
    if (drain_pop) begin
      q_pop_req[LQ] = 1'b1;
    end

    // Status and exception events
    for (int q = 0; q < NQ; q++) begin
      st_next.count[q] = q_count[q];
      st_next.empty[q] = !q_pop_valid[q];
      st_next.thr[q]   = (queue_threshold[q] != COUNT_RESET)
                         && (q_count[q] >= queue_threshold[q])
                         && !((q == LQ) && ring_mode_en);
      st_next.events[q][EV_OVERFLOW]  = q_ovf[q];
      st_next.events[q][EV_UNDERFLOW] = q_udf[q];
      st_next.events[q][EV_THRESHOLD] = st_next.thr[q] && !st_reg.thr[q];
      st_next.events[q][EV_ASLEEP]    = sleep_hit[q];
      st_next.events[q][EV_COLLISION] = collide[q];
    end
    st_next.exc = |st_next.events;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg       <= '0;
      st_reg.drain <= PQB_DRAIN_IDLE;
      st_reg.empty <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cons_data       = st_reg.cons_data;
  assign cons_data_valid = st_reg.cons_valid;
  assign queue_count     = st_reg.count;
  assign queue_empty     = st_reg.empty;
  assign thr_irq         = st_reg.thr;
  assign queue_events    = st_reg.events;
  assign exc_irq         = st_reg.exc;
  assign drainer_busy    = (st_reg.drain == PQB_DRAIN_BUSY);

  a_drain_start: assert property (@(posedge mclk) disable iff (rst)
    !drainer_busy && ring_mode_en && q_pop_valid[LQ]
    && (q_count[LQ] >= queue_threshold[LQ])
    |-> q_pop_req[LQ] ##1 drainer_busy)
    else $error("drainer did not start at threshold");

  a_drain_keeps: assert property (@(posedge mclk) disable iff (rst)
    drainer_busy && !ring_mode_en && q_pop_valid[LQ] && !head_start
    |-> q_pop_req[LQ] ##1 drainer_busy)
    else $error("drainer abandoned packet when enable cleared");

  a_drain_stops: assert property (@(posedge mclk) disable iff (rst)
    drainer_busy && q_pop_valid[LQ] && head_start
    |-> !q_pop_req[LQ] ##1 !drainer_busy)
    else $error("drainer ran past packet start marker");

  a_small_thr: assert property (@(posedge mclk) disable iff (rst)
    (queue_threshold[1] != COUNT_RESET) && (q_count[1] >= queue_threshold[1])
    |=> thr_irq[1])
    else $error("small queue threshold interrupt missing");

  a_ring_quiet: assert property (@(posedge mclk) disable iff (rst)
    ring_mode_en ##1 ring_mode_en |-> !thr_irq[LQ])
    else $error("threshold interrupt raised in ring mode");

  a_exc_merge: assert property (@(posedge mclk) disable iff (rst)
    ((|q_ovf) || (|q_udf) || (|collide))
    |=> exc_irq && $past(q_ovf) == {queue_events[3][EV_OVERFLOW],
        queue_events[2][EV_OVERFLOW], queue_events[1][EV_OVERFLOW],
        queue_events[0][EV_OVERFLOW]})
    else $error("exception not merged into combined interrupt");
endmodule

// ---- bench/pqb_far_model.sv ----
module pqb_far_model (
  input  wire logic                                        mclk,
  output logic [pqb_pkg::NUM_SOURCES-1:0]                  src_valid,
  output pqb_pkg::pqb_qsel_type [pqb_pkg::NUM_SOURCES-1:0] src_queue,
  output pqb_pkg::pqb_data_type [pqb_pkg::NUM_SOURCES-1:0] src_data,
  output logic [pqb_pkg::NUM_SOURCES-1:0]                  src_end,
  input  wire logic [pqb_pkg::NUM_SOURCES-1:0]             src_ready,
  output logic [pqb_pkg::NUM_CONSUMERS-1:0]                cons_pop_req,
  output pqb_pkg::pqb_qsel_type [pqb_pkg::NUM_CONSUMERS-1:0] cons_pop_queue,
  input  wire logic [pqb_pkg::NUM_CONSUMERS-1:0]           cons_pop_ready,
  input  wire pqb_pkg::pqb_data_type [pqb_pkg::NUM_CONSUMERS-1:0] cons_data,
  input  wire logic [pqb_pkg::NUM_CONSUMERS-1:0]           cons_data_valid,
  input  wire pqb_pkg::pqb_count_type [pqb_pkg::NUM_QUEUES-1:0] queue_count,
  input  wire logic                                        drainer_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import pqb_pkg::*;

  initial begin
    src_valid = '0;
    src_queue = '0;
    src_data = '0;
    src_end = '0;
    cons_pop_req = '0;
    cons_pop_queue = '0;
  end

  // Request held from a falling edge until a rising edge sees ready, for at most 4 rising edges
  task automatic push(int s, int q, pqb_data_type v, logic e, output logic ok);
    @(negedge mclk);
    src_valid[s] = 1'b1;
    src_queue[s] = q[1:0];
    src_data[s] = v;
    src_end[s] = e;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (i > 0) @(negedge mclk);
      #1 ok = src_ready[s];
      @(posedge mclk);
    end
    @(negedge mclk);
    src_valid[s] = 1'b0;
    src_end[s] = 1'b0;
    // Released data never shows the stale word
    src_data[s] = ~v;
  endtask

  task automatic pop(int c, int q, output logic ok, output pqb_data_type v);
    for (int i = 0; i < 50 && q == LARGE_Q && drainer_busy; i++)
      @(negedge mclk);
    ok = 1'b0;
    v = '0;
    if (queue_count[q] != '0) begin
      @(negedge mclk);
      cons_pop_req[c] = 1'b1;
      cons_pop_queue[c] = q[1:0];
      for (int i = 0; i < 4 && !ok; i++) begin
        if (i > 0) @(negedge mclk);
        #1 ok = cons_pop_ready[c];
        @(posedge mclk);
      end
      @(negedge mclk);
      cons_pop_req[c] = 1'b0;
      cons_pop_queue[c] = ~q[1:0];
      v = cons_data[c];
      if (ok && cons_data_valid[c] !== 1'b1) ok = 1'b0;
    end
  endtask

  // Deliberate one-cycle pop past the count, to provoke the underflow event
  task automatic pop_blind(int c, int q);
    @(negedge mclk);
    cons_pop_req[c] = 1'b1;
    cons_pop_queue[c] = q[1:0];
    @(negedge mclk);
    cons_pop_req[c] = 1'b0;
  endtask
endmodule

// ---- bench/pqb_packet_queue_bank_tb.sv ----
module pqb_packet_queue_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pqb_pkg::*;

  // Shallow queues keep fill-to-refusal runs short
  localparam int DQ [0:3] = '{16, 8, 4, 4};

  logic                                mclk;
  logic                                rst;
  logic           [NUM_SOURCES-1:0]    src_valid;
  pqb_qsel_type   [NUM_SOURCES-1:0]    src_queue;
  pqb_data_type   [NUM_SOURCES-1:0]    src_data;
  logic           [NUM_SOURCES-1:0]    src_end;
  logic           [NUM_SOURCES-1:0]    src_ready;
  logic                                packet_mode_en;
  logic                                ring_mode_en;
  pqb_count_type  [NUM_QUEUES-1:0]     queue_threshold;
  logic           [NUM_QUEUES-1:0]     queue_asleep;
  logic           [NUM_QUEUES-1:0]     pop_owner;
  logic           [NUM_CONSUMERS-1:0]  cons_pop_req;
  pqb_qsel_type   [NUM_CONSUMERS-1:0]  cons_pop_queue;
  logic           [NUM_CONSUMERS-1:0]  cons_pop_ready;
  pqb_data_type   [NUM_CONSUMERS-1:0]  cons_data;
  logic           [NUM_CONSUMERS-1:0]  cons_data_valid;
  pqb_count_type  [NUM_QUEUES-1:0]     queue_count;
  logic           [NUM_QUEUES-1:0]     queue_empty;
  logic           [NUM_QUEUES-1:0]     thr_irq;
  pqb_events_type [NUM_QUEUES-1:0]     queue_events;
  logic                                exc_irq;
  logic                                drainer_busy;
  pqb_events_type [NUM_QUEUES-1:0]     ev_seen;
  logic                                exc_seen;
  logic                                seen_clr;
  logic                                ok;
  logic                                ok2;
  pqb_data_type                        d;
  pqb_data_type                        sq[$];
  int                                  errors;
  int                                  num_checks;
  int                                  seed;

  pqb_packet_queue_bank #(.DEPTH_LARGE(DQ[0]), .WIDTH_LARGE(17),
    .DEPTH_Q1(DQ[1]), .DEPTH_Q2(DQ[2]), .DEPTH_Q3(DQ[3])
  ) pqb_packet_queue_bank_inst (
    .mclk(mclk), .rst(rst), .src_valid(src_valid), .src_queue(src_queue),
    .src_data(src_data), .src_end(src_end), .src_ready(src_ready),
    .packet_mode_en(packet_mode_en), .ring_mode_en(ring_mode_en),
    .queue_threshold(queue_threshold), .queue_asleep(queue_asleep),
    .pop_owner(pop_owner), .cons_pop_req(cons_pop_req),
    .cons_pop_queue(cons_pop_queue), .cons_pop_ready(cons_pop_ready),
    .cons_data(cons_data), .cons_data_valid(cons_data_valid),
    .queue_count(queue_count), .queue_empty(queue_empty),
    .thr_irq(thr_irq), .queue_events(queue_events), .exc_irq(exc_irq),
    .drainer_busy(drainer_busy));

  pqb_far_model pqb_far_model_inst (
    .mclk(mclk), .src_valid(src_valid), .src_queue(src_queue),
    .src_data(src_data), .src_end(src_end), .src_ready(src_ready),
    .cons_pop_req(cons_pop_req), .cons_pop_queue(cons_pop_queue),
    .cons_pop_ready(cons_pop_ready), .cons_data(cons_data),
    .cons_data_valid(cons_data_valid), .queue_count(queue_count),
    .drainer_busy(drainer_busy));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // Event bits stay high only while their cause holds, so keep them sticky
  always @(posedge mclk) begin
    ev_seen <= seen_clr ? '0 : (ev_seen | queue_events);
    exc_seen <= seen_clr ? 1'b0 : (exc_seen | exc_irq);
  end

  function automatic pqb_data_type kept(int q, pqb_data_type v);
    return (q == LARGE_Q) ? (v & 32'h0001FFFF) : v;
  endfunction

  task automatic results;
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_word(pqb_data_type got, pqb_data_type exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t word got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic chk_count(pqb_count_type got, pqb_count_type exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic chk_flag(logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic gap;
    repeat (3) @(negedge mclk);
  endtask

  // Sticky event copies are cleared across one rising edge
  task automatic clr_seen;
    seen_clr = 1'b1;
    @(negedge mclk);
    seen_clr = 1'b0;
  endtask

  task automatic wait_busy(logic lvl);
    int i;
    for (i = 0; i < 40 && drainer_busy !== lvl; i++) @(negedge mclk);
    if (i == 40) begin
      errors++;
      $display("ERROR %0t drainer wait ran out", $time);
      results();
    end
  endtask

  task automatic pw(int s, int q, pqb_data_type v, logic e);
    pqb_far_model_inst.push(s, q, v, e, ok);
    chk_flag(ok, 1'b1);
  endtask

  task automatic pc(int q, pqb_data_type v);
    pqb_far_model_inst.pop(pop_owner[q], q, ok, d);
    chk_flag(ok, 1'b1);
    chk_word(d, kept(q, v));
  endtask

  initial begin
    seed = 62362;
    errors = 0;
    num_checks = 0;
    rst = 1'b1;
    seen_clr = 1'b1;
    packet_mode_en = 1'b0;
    ring_mode_en = 1'b0;
    queue_threshold = '0;
    queue_asleep = '0;
    pop_owner = 4'h2;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    seen_clr = 1'b0;
    chk_word(32'(queue_empty), 32'h0000000F);
    chk_count(queue_count[0], COUNT_RESET);
    // Normal mode: a stray end marker must not matter
    for (int s = 0; s < NUM_SOURCES; s++) begin
      d = $random(seed);
      sq.push_back(d);
      pw(s, LARGE_Q, d, s == 1);
    end
    gap();
    chk_count(queue_count[0], 13'h0003);
    pop_owner[0] = 1'b1;
    pqb_far_model_inst.pop(0, LARGE_Q, ok, d);
    chk_flag(ok, 1'b0);
    pop_owner[0] = 1'b0;
    while (sq.size() > 0) pc(LARGE_Q, sq.pop_front());
    packet_mode_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      sq.push_back(d);
      pw(2, LARGE_Q, d, i == 2);
      gap();
      chk_count(queue_count[0], (i < 2) ? 13'h0000 : 13'h0003);
      chk_flag(queue_empty[0], i < 2);
    end
    repeat (2) pc(LARGE_Q, sq.pop_front());
    pc(LARGE_Q, sq.pop_front());
    gap();
    chk_flag(queue_empty[0], 1'b1);
    d = $random(seed);
    sq.push_back(d);
    pw(0, LARGE_Q, d, 1'b1);
    gap();
    chk_count(queue_count[0], 13'h0002);
    repeat (2) pc(LARGE_Q, sq.pop_front());
    for (int q = 1; q < NUM_QUEUES; q++) begin
      queue_threshold[q] = 13'h0002;
      clr_seen();
      for (int n = 0; n <= DQ[q]; n++) begin
        d = $random(seed);
        pqb_far_model_inst.push(n % 3, q, d, 1'b0, ok);
        if (ok) sq.push_back(d);
        chk_flag(ok, n < DQ[q]);
      end
      gap();
      chk_count(queue_count[q], 13'(DQ[q]));
      chk_flag(thr_irq[q], 1'b1);
      chk_flag(ev_seen[q][EV_THRESHOLD], 1'b1);
      chk_flag(ev_seen[q][EV_OVERFLOW], 1'b1);
      chk_flag(exc_seen, 1'b1);
      while (sq.size() > 0) pc(q, sq.pop_front());
      gap();
      chk_flag(thr_irq[q], 1'b0);
      pqb_far_model_inst.pop_blind(pop_owner[q], q);
      gap();
      chk_flag(ev_seen[q][EV_UNDERFLOW], 1'b1);
    end
    queue_asleep[3] = 1'b1;
    pqb_far_model_inst.push(1, 3, 32'h0000ABCD, 1'b0, ok);
    chk_flag(ok, 1'b0);
    chk_flag(ev_seen[3][EV_ASLEEP], 1'b1);
    queue_asleep[3] = 1'b0;
    fork
      pqb_far_model_inst.push(0, 2, 32'h00001111, 1'b0, ok);
      pqb_far_model_inst.push(1, 2, 32'h00002222, 1'b0, ok2);
    join
    chk_flag(ok, 1'b1);
    chk_flag(ok2, 1'b1);
    chk_flag(ev_seen[2][EV_COLLISION], 1'b1);
    pc(2, 32'h00001111);
    pc(2, 32'h00002222);
    queue_threshold[0] = 13'h0004;
    ring_mode_en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      d = $random(seed);
      d[16] = (i == 0 || i == 3);
      pw(i % 3, LARGE_Q, d, i == 2 || i == 4);
      if (i == 2) chk_flag(drainer_busy, 1'b0);
    end
    wait_busy(1'b1);
    wait_busy(1'b0);
    gap();
    chk_count(queue_count[0], 13'h0002);
    chk_flag(thr_irq[0], 1'b0);
    // Count after the next drain equals the threshold, so a restart shows
    queue_threshold[0] = 13'h0003;
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      d[16] = (i == 0);
      sq.push_back(d);
      pw(0, LARGE_Q, d, i == 2);
    end
    wait_busy(1'b1);
    ring_mode_en = 1'b0;
    wait_busy(1'b0);
    gap();
    chk_count(queue_count[0], 13'h0003);
    chk_flag(drainer_busy, 1'b0);
    chk_flag(thr_irq[0], 1'b1);
    while (sq.size() > 0) pc(LARGE_Q, sq.pop_front());
    gap();
    results();
  end
endmodule
